//--- hdl/lcdhi_defs.svh
`ifndef LCDHI_DEFS_SVH
`define LCDHI_DEFS_SVH

// Link codes on the three strap pins
`define LCDHI_M_SPI3      3'h0
`define LCDHI_M_SPI4      3'h1
`define LCDHI_M_I80       3'h2
`define LCDHI_M_M68       3'h3
`define LCDHI_M_I2C       3'h6
`define LCDHI_M_SER3      3'h5

// Write address space
`define LCDHI_X_FIRST     7'h00
`define LCDHI_X_LAST      7'h65
`define LCDHI_Y_FIRST     4'h0
`define LCDHI_Y_LAST      4'h8
`define LCDHI_Y_ICON      4'hA

// Row scan
`define LCDHI_ROWS_FULL   7'h43
`define LCDHI_ROWS_PART   7'h40
`define LCDHI_ICON_ROW    7'h43
`define LCDHI_SCAN_DIV    8'h10

// Serial framing
`define LCDHI_BITS_SPI    4'h7
`define LCDHI_BITS_SER    4'h8
`define LCDHI_TX_LAST     4'h7
`define LCDHI_SDO_BIT     5
`define LCDHI_SCLK_BIT    6
`define LCDHI_SDI_BIT     7
`define LCDHI_STATUS_CMD  8'hFF

`endif

//--- hdl/lcdhi_pkg.sv
package lcdhi_pkg;

    typedef logic [2:0] lcdhi_link_t;

    // Serial reply shifter
    typedef enum logic [1:0] {
        TX_OFF,
        TX_SHIFT,
        TX_DONE
    } lcdhi_tx_e;

endpackage : lcdhi_pkg

//--- hdl/lcdhi_rx_if.sv
`timescale 1ns/1ps

interface lcdhi_rx_if;
    logic       valid;
    logic [7:0] data;
    logic       dcBit;
    logic       abort;

    modport src (output valid, output data, output dcBit, output abort);
    modport dst (input valid, input data, input dcBit, input abort);
endinterface : lcdhi_rx_if

//--- hdl/lcdhi_serial_rx.sv
`timescale 1ns/1ps
`include "lcdhi_defs.svh"

module lcdhi_serial_rx (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Synchronised link pins
    input  wire logic       ceLow,
    input  wire logic       sclkRise,
    input  wire logic       sclkFall,
    input  wire logic       sdi,
    // Framing and reply
    input  wire logic       nineBit,
    input  wire logic       txStart,
    input  wire logic [7:0] statusByte,
    // Byte stream
    lcdhi_rx_if.src         rx,
    // Serial reply pin
    output logic            sdo,
    output logic            sdoOe
);

    logic [3:0]            bitCnt_q;
    logic [7:0]            rxSh_q;
    logic [7:0]            txSh_q;
    logic [3:0]            txCnt_q;
    lcdhi_pkg::lcdhi_tx_e  txSt_q;

    // Reception is locked out while a reply is pending
    wire [3:0] lastBit  = nineBit ? `LCDHI_BITS_SER : `LCDHI_BITS_SPI;
    wire       rxTake   = ceLow && sclkRise && (txSt_q == lcdhi_pkg::TX_OFF);
    wire       byteDone = rxTake && (bitCnt_q == lastBit);

    // Shift in MSB first, drop partial byte when chip enable rises
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bitCnt_q <= 4'h0;
            rxSh_q   <= 8'h00;
            rx.valid <= 1'b0;
            rx.data  <= 8'h00;
            rx.dcBit <= 1'b0;
            rx.abort <= 1'b0;
        end else begin
            rx.valid <= byteDone;
            rx.abort <= !ceLow && (bitCnt_q != 4'h0);
            if (!ceLow) begin
                bitCnt_q <= 4'h0;
            end else if (rxTake) begin
                rxSh_q   <= {rxSh_q[6:0], sdi};
                bitCnt_q <= byteDone ? 4'h0 : bitCnt_q + 4'h1;
            end
            if (byteDone) begin
                rx.data  <= {rxSh_q[6:0], sdi};
                rx.dcBit <= rxSh_q[7];
            end
        end
    end

    // Reply shifts on falling clock, released after last rising edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            txSt_q  <= lcdhi_pkg::TX_OFF;
            txSh_q  <= 8'h00;
            txCnt_q <= 4'h0;
            sdo     <= 1'b0;
            sdoOe   <= 1'b0;
        end else if (!ceLow) begin
            txSt_q <= lcdhi_pkg::TX_OFF;
            sdoOe  <= 1'b0;
        end else begin
            unique case (txSt_q)
                lcdhi_pkg::TX_OFF: begin
                    if (txStart) begin
                        txSh_q  <= statusByte;
                        txCnt_q <= 4'h0;
                        txSt_q  <= lcdhi_pkg::TX_SHIFT;
                    end
                end
                lcdhi_pkg::TX_SHIFT: begin
                    if (sclkFall) begin
                        sdo     <= txSh_q[7];
                        sdoOe   <= 1'b1;
                        txSh_q  <= {txSh_q[6:0], 1'b0};
                        txCnt_q <= txCnt_q + 4'h1;
                        if (txCnt_q == `LCDHI_TX_LAST) begin
                            txSt_q <= lcdhi_pkg::TX_DONE;
                        end
                    end
                end
                lcdhi_pkg::TX_DONE: begin
                    if (sclkRise) begin
                        sdoOe <= 1'b0;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_cnt_clear: assert property (!ceLow |=> bitCnt_q == 4'h0)
        else $error("bit counter not cleared while deselected");
    a_sdo_fall: assert property ($changed(sdo) |-> $past(sclkFall))
        else $error("reply bit moved off a falling clock");
    a_abort_once: assert property (rx.abort |=> !rx.abort)
        else $error("partial byte drop lasted more than a cycle");

endmodule : lcdhi_serial_rx

//--- hdl/lcdhi_addr_gen.sv
`timescale 1ns/1ps
`include "lcdhi_defs.svh"

module lcdhi_addr_gen (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Loads and stepping
    input  wire logic       setX,
    input  wire logic [6:0] xValue,
    input  wire logic       setY,
    input  wire logic [3:0] yValue,
    input  wire logic       step,
    input  wire logic       vertical,
    // Current pointers
    output logic      [6:0] addrX,
    output logic      [3:0] addrY
);

    // Wrap points and the icon bank
    wire       xLast = addrX == `LCDHI_X_LAST;
    wire       yLast = addrY == `LCDHI_Y_LAST;
    wire       icon  = addrY == `LCDHI_Y_ICON;
    wire [6:0] xInc  = xLast ? `LCDHI_X_FIRST : addrX + 7'h01;
    wire [3:0] yInc  = yLast ? `LCDHI_Y_FIRST : addrY + 4'h1;

    // Icon bank ignores vertical mode and never leaves by itself
    wire       xMove = icon || !vertical || yLast;
    wire       yMove = !icon && (vertical || xLast);
    wire [6:0] x_d   = setX ? xValue : (step && xMove) ? xInc : addrX;
    wire [3:0] y_d   = setY ? yValue : (step && yMove) ? yInc : addrY;

    // Pointers load independently of each other
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            addrX <= `LCDHI_X_FIRST;
            addrY <= `LCDHI_Y_FIRST;
        end else begin
            addrX <= x_d;
            addrY <= y_d;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    wire noLoad = !setX && !setY;

    a_horiz_step: assert property (
        step && noLoad && !vertical && !icon && !xLast
        |=> addrX == $past(addrX) + 7'h01 && $stable(addrY))
        else $error("horizontal step wrong");
    a_vert_step: assert property (
        step && noLoad && vertical && !icon && !yLast
        |=> addrY == $past(addrY) + 4'h1 && $stable(addrX))
        else $error("vertical step wrong");
    a_last_wrap: assert property (
        step && noLoad && xLast && yLast
        |=> addrX == `LCDHI_X_FIRST && addrY == `LCDHI_Y_FIRST)
        else $error("last address did not wrap to origin");
    a_icon_stay: assert property (
        step && icon && !setY |=> addrY == `LCDHI_Y_ICON)
        else $error("icon bank left without a load");

endmodule : lcdhi_addr_gen

//--- hdl/lcdhi_top.sv
`timescale 1ns/1ps
`include "lcdhi_defs.svh"

// Behaviour
// - straps pick SPI, parallel or serial link
// - column and bank pointers load separately
// - columns 0..101, banks 0..8 and 10
// - horizontal mode steps column, wraps into bank
// - vertical mode steps bank, wraps into column
// - last cell wraps both pointers to origin
// - icon bank only by load, left only by load
// - icon writes ignore vertical, keep mirrors
// - bit order picks top row bit
// - column mirror maps 0 to column 101
// - row mirror acts in partial-mode scan only, instantly
// - scan up or down, icon row first on partial swap, else last
// - normal mode plain scan, partial 65 rows
// - eight data bits both ways on parallel
// - 6800 select pair decodes three operations
// - 6800 strobe on enable or chip select
// - 8080 strobe pattern decodes three operations
// - four-line select high means display data
// - length command counts data bytes, then command
// - deselect mid byte drops it, next command
// - status reply out on falling serial clock
// - pointer steps after every data byte
module lcdhi_top #(
    parameter logic [7:0] STATUS_CMD = `LCDHI_STATUS_CMD,
    parameter logic [7:0] SCAN_DIV   = `LCDHI_SCAN_DIV
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Link select straps
    input  wire logic       linkSelectBit2,
    input  wire logic       linkSelectBit1,
    input  wire logic       linkSelectBit0,
    // Host strobes
    input  wire logic       dataCmdSel,
    input  wire logic       rdWrSel,
    input  wire logic       enableRd,
    input  wire logic       chipEnableLowN,
    // Data pins, serial clock on bit 6, serial data in on bit 7
    input  wire logic [7:0] dbIn,
    output logic      [7:0] dbOut,
    output logic      [7:0] dbOe,
    // Display settings
    input  wire logic       columnMirror,
    input  wire logic       rowMirror,
    input  wire logic       msbOnTop,
    input  wire logic       verticalAddr,
    input  wire logic       bottomRowSwap,
    input  wire logic       normalMode,
    input  wire logic [7:0] statusIn,
    // Pointer loads and data length
    input  wire logic       setX,
    input  wire logic [6:0] xValue,
    input  wire logic       setY,
    input  wire logic [3:0] yValue,
    input  wire logic       dataLenLoad,
    input  wire logic [7:0] dataLen,
    // Decoded commands
    output logic            cmdValid,
    output logic      [7:0] cmdByte,
    // Display memory write port
    output logic            memWrEn,
    output logic      [6:0] memCol,
    output logic      [3:0] memBank,
    output logic      [7:0] memData,
    // Pointer and scan state
    output logic      [6:0] addrX,
    output logic      [3:0] addrY,
    output logic      [6:0] scanRow,
    output logic      [2:0] linkMode
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int PINS = 15;

    wire  [PINS-1:0] pinRaw = {linkSelectBit2, linkSelectBit1,
                               linkSelectBit0, dataCmdSel, rdWrSel,
                               enableRd, chipEnableLowN, dbIn};
    logic [PINS-1:0] pinMeta_q;
    logic [PINS-1:0] pinSync_q;

    // Two stages per pin; only the second stage feeds logic
    for (genvar i = 0; i < PINS; i++) begin : g_sync
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                pinMeta_q[i] <= 1'b0;
                pinSync_q[i] <= 1'b0;
            end else begin
                pinMeta_q[i] <= pinRaw[i];
                pinSync_q[i] <= pinMeta_q[i];
            end
        end
    end

    // Named views of the synchronised pins
    wire [2:0] strapS = pinSync_q[14:12];
    wire       dcS    = pinSync_q[11];
    wire       rwS    = pinSync_q[10];
    wire       enS    = pinSync_q[9];
    wire       ceLow  = !pinSync_q[8];
    wire [7:0] dbS    = pinSync_q[7:0];
    wire       sclkS  = dbS[`LCDHI_SCLK_BIT];
    wire       sdiS   = dbS[`LCDHI_SDI_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Link decode

    lcdhi_pkg::lcdhi_link_t linkMode_q;

    // Straps are watched continuously; they are tied on the board
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            linkMode_q <= `LCDHI_M_SPI3;
        end else begin
            linkMode_q <= strapS;
        end
    end

    wire modeSpi3 = linkMode_q == `LCDHI_M_SPI3;
    wire modeSpi4 = linkMode_q == `LCDHI_M_SPI4;
    wire modeSer3 = linkMode_q == `LCDHI_M_SER3;
    wire modeM68  = linkMode_q == `LCDHI_M_M68;
    wire modeI80  = linkMode_q == `LCDHI_M_I80;
    wire serMode  = modeSpi3 || modeSpi4 || modeSer3;
    wire parMode  = modeM68 || modeI80;

    ////////////////////////////////////////////////////////////////////////
    // Parallel port

    logic       parWrPrev_q;
    logic [7:0] parLat_q;
    logic       parDcLat_q;

    // Write phase looks alike in both styles: enable or read high,
    // read/write or write low. Chip select joins in, so a 6800 host
    // may clock with either enable or chip select.
    wire parWr   = parMode && ceLow && enS && !rwS;
    wire parRd   = parMode && ceLow && !dcS && rwS
                   && (modeM68 ? enS : !enS);
    wire parDone = parWrPrev_q && !parWr;

    // Hold the last byte seen during the write phase
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            parWrPrev_q <= 1'b0;
            parLat_q    <= 8'h00;
            parDcLat_q  <= 1'b0;
        end else begin
            parWrPrev_q <= parWr;
            if (parWr) begin
                parLat_q   <= dbS;
                parDcLat_q <= dcS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial port

    logic sclkPrev_q;
    logic txStart_q;
    logic sdo;
    logic sdoOe;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclkS;
        end
    end

    wire sclkRise = sclkS && !sclkPrev_q;
    wire sclkFall = !sclkS && sclkPrev_q;

    lcdhi_rx_if rxIf ();

    lcdhi_serial_rx u_rx (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .ceLow      (ceLow && serMode),
        .sclkRise   (sclkRise),
        .sclkFall   (sclkFall),
        .sdi        (sdiS),
        .nineBit    (modeSer3),
        .txStart    (txStart_q),
        .statusByte (statusIn),
        .rx         (rxIf.src),
        .sdo        (sdo),
        .sdoOe      (sdoOe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Byte classification

    logic [8:0] remain_q;

    // Without a select line or ninth bit the length counter alone says data
    wire       serByte    = serMode && rxIf.valid;
    wire       remainLive = remain_q != 9'h000;
    wire       serIsData  = modeSpi4 ? dcS
                          : modeSer3 ? rxIf.dcBit
                          : remainLive;
    wire       byteValid  = parDone || serByte;
    wire [7:0] byteVal    = parDone ? parLat_q : rxIf.data;
    wire       byteIsData = parDone ? parDcLat_q : serIsData;
    wire       dataWr     = byteValid && byteIsData;
    wire       cmdWr      = byteValid && !byteIsData;
    wire [7:0] revData    = {<<{byteVal}};

    // A dropped byte ends the stream, so the next one is a command
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            remain_q <= 9'h000;
        end else if (rxIf.abort) begin
            remain_q <= 9'h000;
        end else if (dataLenLoad) begin
            remain_q <= {1'b0, dataLen} + 9'h001;
        end else if (serByte && modeSpi3 && remainLive) begin
            remain_q <= remain_q - 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands and memory writes

    lcdhi_addr_gen u_addr (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .setX     (setX),
        .xValue   (xValue),
        .setY     (setY),
        .yValue   (yValue),
        .step     (dataWr),
        .vertical (verticalAddr),
        .addrX    (addrX),
        .addrY    (addrY)
    );

    // Mirroring of columns happens on the way into memory
    wire [6:0] physCol = columnMirror ? `LCDHI_X_LAST - addrX
                                      : addrX;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmdValid  <= 1'b0;
            cmdByte   <= 8'h00;
            txStart_q <= 1'b0;
        end else begin
            cmdValid  <= cmdWr;
            txStart_q <= cmdWr && serMode && (byteVal == STATUS_CMD);
            if (cmdWr) begin
                cmdByte <= byteVal;
            end
        end
    end

    // Bank index is written as is; row mirror is left to the scan
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            memWrEn <= 1'b0;
            memCol  <= `LCDHI_X_FIRST;
            memBank <= `LCDHI_Y_FIRST;
            memData <= 8'h00;
        end else begin
            memWrEn <= dataWr;
            if (dataWr) begin
                memCol  <= physCol;
                memBank <= addrY;
                memData <= msbOnTop ? revData : byteVal;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data pin drivers

    // Parallel status read drives all eight pins; serial only its pin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dbOut <= 8'h00;
            dbOe  <= 8'h00;
        end else if (parRd) begin
            dbOut <= statusIn;
            dbOe  <= '1;
        end else begin
            dbOut <= 8'(sdo) << `LCDHI_SDO_BIT;
            dbOe  <= 8'(sdoOe && serMode) << `LCDHI_SDO_BIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Row scan order

    logic [7:0] scanDiv_q;
    logic [6:0] scanIdx_q;

    // Partial mode limits the rows and enables mirror and swap
    wire       scanTick  = scanDiv_q == SCAN_DIV - 8'h01;
    wire       partial   = !normalMode;
    wire [6:0] rowsCnt   = partial ? `LCDHI_ROWS_PART : `LCDHI_ROWS_FULL;
    wire       swapIcon  = partial && bottomRowSwap;
    wire       mirScan   = partial && rowMirror;
    wire [6:0] iconIdx   = swapIcon ? 7'h00 : rowsCnt;
    wire [6:0] rowIdx    = swapIcon ? scanIdx_q - 7'h01 : scanIdx_q;
    wire [6:0] scanRow_d = (scanIdx_q == iconIdx) ? `LCDHI_ICON_ROW
                         : mirScan ? rowsCnt - 7'h01 - rowIdx
                         : rowIdx;
    wire       scanEnd   = scanIdx_q >= rowsCnt;

    // Image follows the mirror at once: nothing in memory moves
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scanDiv_q <= 8'h00;
            scanIdx_q <= 7'h00;
            scanRow   <= 7'h00;
        end else begin
            scanDiv_q <= scanTick ? 8'h00 : scanDiv_q + 8'h01;
            if (scanTick) begin
                scanIdx_q <= scanEnd ? 7'h00 : scanIdx_q + 7'h01;
                scanRow   <= scanRow_d;
            end
        end
    end

    assign linkMode = linkMode_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_strap_decode: assert property (
        1'b1 |=> linkMode_q == $past(strapS))
        else $error("link mode does not follow straps");
    a_col_mirror: assert property (
        dataWr && columnMirror
        |=> memWrEn && memCol == `LCDHI_X_LAST - $past(addrX))
        else $error("mirrored column wrong");
    a_bit_order: assert property (
        dataWr && msbOnTop |=> memData == $past(revData))
        else $error("bit order not applied");
    a_spi4_cmd: assert property (
        serByte && modeSpi4 && !dcS |=> cmdValid && !memWrEn)
        else $error("four-line command stored as data");
    a_par_cmd: assert property (
        parDone && !parDcLat_q |=> cmdValid && !memWrEn)
        else $error("parallel command stored as data");
    a_len_data: assert property (
        serByte && modeSpi3 && remainLive && !rxIf.abort
        |=> memWrEn && !cmdValid)
        else $error("counted byte not stored as data");
    a_abort_len: assert property (
        rxIf.abort && !dataLenLoad |=> remain_q == 9'h000)
        else $error("data stream survived a dropped byte");
    a_status_quiet: assert property (
        parRd && !parDone && !setX && !setY
        |=> !memWrEn && $stable(addrX) && $stable(addrY))
        else $error("status read disturbed memory");
    a_part_rows: assert property (
        scanTick && partial && scanIdx_q < `LCDHI_ROWS_PART
        |=> scanIdx_q <= `LCDHI_ROWS_PART)
        else $error("partial scan ran past its rows");

    c_data_write: cover property (dataWr ##1 memWrEn);
    c_icon_write: cover property (dataWr && addrY == `LCDHI_Y_ICON);
    c_status_tx:  cover property (txStart_q);
    c_abort:      cover property (rxIf.abort);

endmodule : lcdhi_top

//--- verification/lcdhi_host_model.sv
`timescale 1ns/1ps

module lcdhi_host_model (
    // Host pins
    output logic       dc,
    output logic       wrN,
    output logic       rdN,
    output logic       ceN,
    output logic [7:0] db
);
    // Idle: deselected, strobes high, link clock held low
    initial begin
        {dc, wrN, rdN, ceN} = 4'hF;
        db = 8'h00;
    end

    // 8080 write, phase and gap longer than the synchronisers
    task automatic par_wr(input logic d, input logic [7:0] b);
        {dc, ceN, db} = {d, 1'b0, b};
        wrN = 1'b0;
        #24 wrN = 1'b1;
        #8 ceN = 1'b1;
        db = ~b; // Released bus shows no stale byte
        #40;
    endtask : par_wr

    // 8080 status read, held long enough to look at the pins mid-phase
    task automatic par_rd();
        {dc, ceN, rdN} = 3'b000;
        #40 {rdN, ceN} = 2'b11;
        #40;
    endtask : par_rd

    // Serial frame, MSB first; n below 8 aborts mid byte
    task automatic spi_wr(input logic d, input logic [7:0] b, input int n);
        {ceN, db[6]} = 2'b00; // Link clock low at select, not stale
        dc = d;
        for (int i = 7; i > 7 - n; i--) begin
            db[7] = b[i];
            #62.5 db[6] = 1'b1;
            #62.5 db[6] = 1'b0;
        end
        ceN = 1'b1;
        db[7] = ~db[7];
        #250;
    endtask : spi_wr
endmodule : lcdhi_host_model

//--- verification/lcdhi_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin numChecks++; if ((s) !== (e)) begin nErrors++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end

module lcdhi_top_tb;
    logic ref_clk = 1'b0, reset = 1'b1, setX = 1'b0, setY = 1'b0;
    logic [2:0] link = 3'h2;
    logic cm = 1'b0, msb = 1'b0, vert = 1'b0, lenLd = 1'b0;
    logic [6:0] xValue = 7'h00, memCol, addrX;
    logic [3:0] yValue = 4'h0, memBank, addrY;
    logic dc, wrN, rdN, ceN, cmdValid, memWrEn;
    logic [7:0] db, cmdByte, memData, dataLen = 8'h00;
    logic [31:0] seed = 32'h11C0;
    logic [18:0] expQ[$];
    logic [7:0] cmdQ[$];
    int mx, my, nErrors, numChecks;
    logic nm = 1'b1, rm = 1'b0, scanOn = 1'b0;
    logic [6:0] scanRow, lastRow = 7'h00;
    logic [2:0] linkMode;
    logic [7:0] dbOut, dbOe, expCmd;
    logic [18:0] expMem;

    lcdhi_host_model u_lcdhi_host_model (.dc, .wrN, .rdN, .ceN, .db);
    lcdhi_top u_lcdhi_top (.ref_clk, .reset, .linkSelectBit2(link[2]),
        .linkSelectBit1(link[1]), .linkSelectBit0(link[0]),
        .dataCmdSel(dc), .rdWrSel(wrN), .enableRd(rdN), .chipEnableLowN(ceN),
        .dbIn(db), .dbOut, .dbOe, .columnMirror(cm), .rowMirror(rm),
        .msbOnTop(msb), .verticalAddr(vert), .bottomRowSwap(1'b0),
        .normalMode(nm), .statusIn(8'h5A), .setX, .xValue, .setY, .yValue,
        .dataLenLoad(lenLd), .dataLen, .cmdValid, .cmdByte, .memWrEn, .memCol,
        .memBank, .memData, .addrX, .addrY, .scanRow, .linkMode);

    always #4 ref_clk = ~ref_clk;

    // Every write and command the design reports is matched in order
    always @(posedge ref_clk) begin
        if (memWrEn === 1'b1) begin
            expMem = expQ.pop_front();
            `CHK("mem", expMem, {memCol, memBank, memData})
        end
        if (cmdValid === 1'b1) begin
            expCmd = cmdQ.pop_front();
            `CHK("cmd", expCmd, cmdByte)
        end
    end

    // Next scanned row; partial mode here always runs mirrored
    function automatic int nextRow(input int r);
        if (r == 67) return nm ? 0 : 63;
        if (nm) return r + 1;
        return (r == 0) ? 67 : r - 1;
    endfunction : nextRow

    // Every step of the row scan is held against the order model
    always @(posedge ref_clk) begin
        if (scanOn && scanRow !== lastRow)
            `CHK("scan", nextRow(lastRow), scanRow)
        lastRow <= scanRow;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task automatic giveVerdict();
        if (nErrors == 0 && numChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : giveVerdict

    task automatic ld(input int x, input int y);
        @(posedge ref_clk) #1 {setX, setY} = 2'b11;
        {xValue, yValue} = {x[6:0], y[3:0]};
        mx = x;
        my = y;
        @(posedge ref_clk) #1 {setX, setY} = 2'b00;
    endtask : ld

    // Model one byte: d says how the device must treat it
    task automatic put(input logic d);
        logic [7:0] b;
        logic [7:0] r;
        b = rnd();
        r = {<<{b}};
        if (d) begin
            expQ.push_back({cm ? 7'h65 - mx[6:0] : mx[6:0], my[3:0],
                            msb ? r : b});
            if (my == 10 || !vert) begin
                mx = (mx + 1) % 102;
                if (mx == 0 && my != 10) my = (my + 1) % 9;
            end else begin
                my = (my + 1) % 9;
                if (my == 0) mx = (mx + 1) % 102;
            end
        end else cmdQ.push_back(b);
        if (link[1]) u_lcdhi_host_model.par_wr(d, b);
        else u_lcdhi_host_model.spi_wr(d ^ ~link[0], b, 8);
        `CHK("addrX", mx[6:0], addrX)
        `CHK("addrY", my[3:0], addrY)
    endtask : put

    initial begin
        repeat (12) @(posedge ref_clk);
        #1 reset = 1'b0;
        scanOn = 1'b1;
        repeat (3) @(posedge ref_clk);
        ld(100, 7);
        `CHK("mode", link, linkMode)
        repeat (4) put(1'b1);
        put(1'b0);
        fork
            u_lcdhi_host_model.par_rd();
            #33 begin
                `CHK("dbOut", 8'h5A, dbOut)
                `CHK("dbOe", 8'hFF, dbOe)
            end
        join
        `CHK("rdOe", 8'h00, dbOe)
        `CHK("rdX", mx[6:0], addrX)
        `CHK("rdY", my[3:0], addrY)
        ld(100, 8);
        repeat (2) put(1'b1);
        {vert, msb, cm, rm} = 4'hF;
        ld(5, 7);
        repeat (3) put(1'b1);
        ld(101, 10);
        repeat (2) put(1'b1);
        link = 3'h3;
        repeat (4) @(posedge ref_clk);
        #1 put(1'b1);
        `CHK("mode", link, linkMode)
        put(1'b0);
        link = 3'h1;
        repeat (4) @(posedge ref_clk);
        put(1'b1);
        put(1'b0);
        link = 3'h0;
        dataLen = 8'h01;
        @(posedge ref_clk) #1 lenLd = 1'b1;
        @(posedge ref_clk) #1 lenLd = 1'b0;
        put(1'b1);
        u_lcdhi_host_model.spi_wr(1'b1, 8'hC3, 5);
        put(1'b0);
        @(posedge ref_clk) #1 {scanOn, nm} = 2'b00;
        wait (scanRow == 7'h43);
        @(posedge ref_clk) #1 scanOn = 1'b1;
        repeat (1100) @(posedge ref_clk);
        `CHK("left", 0, expQ.size() + cmdQ.size())
        giveVerdict();
    end

    initial begin
        #500000 nErrors++;
        giveVerdict();
    end
endmodule : lcdhi_top_tb
